//--- hdl/sfs_pkg.sv
// Constants shared by the standby fail-safe supervisor and its register store.
// Assumes a 10 MHz system clock and 8-bit register offsets from the SMBus slave engine.
package sfs_pkg;
   localparam logic [7:0]  SFS_ADDR_ADAPT_ONE   = 8'h36;
   localparam logic [7:0]  SFS_ADDR_BOARD_TEST  = 8'h6F;
   localparam int          SFS_STBY_OPT_BIT     = 1;
   localparam int          SFS_BOARD_TEST_BIT   = 0;
   localparam logic [7:0]  SFS_ADAPT_ONE_RESET  = 8'h00;
   localparam logic [7:0]  SFS_BOARD_TEST_RESET = 8'h00;
   localparam logic [7:0]  SFS_UNMAPPED_READ    = 8'h00;
   localparam int unsigned SFS_CLK_FREQ_KHZ     = 10000;
   localparam int unsigned SFS_FAILSAFE_MS      = 4600;
   // Longest time, so the product is taken as is and never rounded up.
   localparam int unsigned SFS_FAILSAFE_CYCLES  = SFS_FAILSAFE_MS * SFS_CLK_FREQ_KHZ;
   localparam int          SFS_FS_CNT_W         = 26;
   localparam int          SFS_THERMAL_EVENT_PIN_TMR_W      = 16;

   typedef enum logic [1:0] {
      SFS_POLL   = 2'b00,
      SFS_COUNT  = 2'b01,
      SFS_FULL   = 2'b11,
      SFS_NORMAL = 2'b10
   } sfs_fs_state_t;
endpackage

//--- hdl/sfs_regmem.sv
// Register store for the two supervisor registers, with registered read data.
// Assumes single-cycle write and read strobes from the SMBus slave engine.
`timescale 1ns/100ps
module sfs_regmem
   import sfs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       load_dflt,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   output logic      [7:0] adapt_one,
   output logic      [7:0] board_test
);
   logic [7:0] adapt_q, adapt_d;
   logic [7:0] test_q,  test_d;
   logic [7:0] rdata_q, rdata_d;

   always_comb begin
      adapt_d = adapt_q;
      test_d  = test_q;
      rdata_d = rdata_q;
      // Defaults win over a write in the same cycle, since the write predates the load.
      if (load_dflt) begin
         adapt_d = SFS_ADAPT_ONE_RESET;
         test_d  = SFS_BOARD_TEST_RESET;
      end else if (wr) begin
         if (addr == SFS_ADDR_ADAPT_ONE) adapt_d = wdata;
         if (addr == SFS_ADDR_BOARD_TEST) test_d = wdata;
      end
      if (rd) begin
         case (addr)
            SFS_ADDR_ADAPT_ONE:  rdata_d = adapt_q;
            SFS_ADDR_BOARD_TEST: rdata_d = test_q;
            default:             rdata_d = SFS_UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adapt_q <= SFS_ADAPT_ONE_RESET;
         test_q  <= SFS_BOARD_TEST_RESET;
         rdata_q <= SFS_UNMAPPED_READ;
      end else if (ce) begin
         adapt_q <= adapt_d;
         test_q  <= test_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata      = rdata_q;
   assign adapt_one  = adapt_q;
   assign board_test = test_q;
endmodule

//--- hdl/sfs_supervisor.sv
// Standby core-rail protection, power-on fail-safe fan timer and board test enable.
// Assumes an SMBus slave engine in front that decodes transactions into register
// strokes and an address-match pulse, and an analog front end with limit comparators.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module sfs_supervisor
   import sfs_pkg::*;
#(
   parameter int unsigned FAILSAFE_CYCLES = SFS_FAILSAFE_CYCLES
)
(
   input  wire logic                       CLK_SYS,
   input  wire logic                       RST_N,
   input  wire logic                       CE,
   input  wire logic                       REG_WR,
   input  wire logic                       REG_RD,
   input  wire logic [7:0]                 REG_ADDR,
   input  wire logic [7:0]                 REG_WDATA,
   output logic      [7:0]                 REG_RDATA,
   input  wire logic                       ADDR_MATCH,
   input  wire logic                       ADDR_ACK,
   input  wire logic                       ON_STANDBY,
   input  wire logic                       CORE_RAIL_BELOW_LOW,
   input  wire logic                       CORE_RAIL_ABOVE_POLL,
   input  wire logic                       CORE_ALERT_EN,
   input  wire logic                       CORE_FLAG_CLR,
   input  wire logic                       THERMAL_EVENT_PIN_EVENT_N,
   input  wire logic                       SHUTDOWN_REQ,
   input  wire logic                       SMBALERT_N_I,
   output logic                            SMBALERT_N_O,
   output logic                            SMBALERT_OE,
   output logic                            CORE_RAIL_FLAG,
   output logic                            STBY_PROTECT,
   output logic [SFS_THERMAL_EVENT_PIN_TMR_W-1:0]      THERMAL_EVENT_PIN_TIMER,
   output logic                            DYN_FAN_START_TEMPERATURE_ALLOW,
   output logic                            SHUTDOWN_ENTER,
   output logic                            BOARD_TEST_EN,
   output logic                            FANS_FULL,
   output logic                            LOAD_DEFAULTS,
   output logic                            NORMAL_OP
);
   localparam logic [SFS_FS_CNT_W-1:0] FS_LAST = SFS_FS_CNT_W'(FAILSAFE_CYCLES - 1);

   logic [7:0]                 adapt_one, board_test;
   logic                       addressed;
   logic                       prot_q, prot_d, flag_q, flag_d;
   logic [SFS_THERMAL_EVENT_PIN_TMR_W-1:0] ttmr_q, ttmr_d;
   sfs_fs_state_t              fs_q, fs_d;
   logic [SFS_FS_CNT_W-1:0]    cnt_q, cnt_d;
   logic                       full_q, full_d, load_q, load_d;

   ////////////////////////////////////////////////////////////////////////////
   sfs_regmem u_regmem (
      .clk        (CLK_SYS),
      .rst_n      (RST_N),
      .ce         (CE),
      .load_dflt  (load_q),
      .wr         (REG_WR),
      .rd         (REG_RD),
      .addr       (REG_ADDR),
      .wdata      (REG_WDATA),
      .rdata      (REG_RDATA),
      .adapt_one  (adapt_one),
      .board_test (board_test)
   );

   // Traffic for other slaves never qualifies, so a busy bus cannot hide a hung host.
   assign addressed     = ADDR_MATCH & ADDR_ACK;
   assign BOARD_TEST_EN = board_test[SFS_BOARD_TEST_BIT];

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      prot_d = adapt_one[SFS_STBY_OPT_BIT] & ON_STANDBY & CORE_RAIL_BELOW_LOW;
      flag_d = flag_q;
      if (CORE_FLAG_CLR) flag_d = 1'b0;
      // Set beats clear so an entry in the clearing cycle is not lost.
      if (prot_d && !prot_q) flag_d = 1'b1;
      ttmr_d = ttmr_q;
      // The timer freezes rather than clears, so sleep time never counts as heat.
      if (!prot_q && !THERMAL_EVENT_PIN_EVENT_N && ttmr_q != '1) begin
         ttmr_d = ttmr_q + SFS_THERMAL_EVENT_PIN_TMR_W'(1);
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         prot_q <= 1'b0;
         flag_q <= 1'b0;
         ttmr_q <= '0;
      end else if (CE) begin
         prot_q <= prot_d;
         flag_q <= flag_d;
         ttmr_q <= ttmr_d;
      end
   end

   assign STBY_PROTECT   = prot_q;
   assign CORE_RAIL_FLAG = flag_q;
   assign THERMAL_EVENT_PIN_TIMER    = ttmr_q;
   assign DYN_FAN_START_TEMPERATURE_ALLOW = !prot_q;
   assign SHUTDOWN_ENTER = SHUTDOWN_REQ & !prot_q;
   // Open-drain alert: driven low only, released otherwise.
   assign SMBALERT_OE    = flag_q & CORE_ALERT_EN;
   assign SMBALERT_N_O   = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      fs_d   = fs_q;
      cnt_d  = cnt_q;
      full_d = full_q;
      load_d = 1'b0;
      case (fs_q)
         SFS_POLL: begin
            if (addressed) begin
               fs_d   = SFS_NORMAL;
               load_d = 1'b1;
            end else if (CORE_RAIL_ABOVE_POLL) begin
               fs_d = SFS_COUNT;
            end
         end
         SFS_COUNT: begin
            if (addressed) begin
               fs_d   = SFS_NORMAL;
               load_d = 1'b1;
            end else if (cnt_q == FS_LAST) begin
               fs_d   = SFS_FULL;
               full_d = 1'b1;
            end else begin
               cnt_d = cnt_q + SFS_FS_CNT_W'(1);
            end
         end
         SFS_FULL: begin
            if (addressed) begin
               fs_d   = SFS_NORMAL;
               full_d = 1'b0;
               load_d = 1'b1;
            end
         end
         SFS_NORMAL: fs_d = SFS_NORMAL;
         default: begin
            fs_d   = SFS_POLL;
            full_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         fs_q   <= SFS_POLL;
         cnt_q  <= '0;
         full_q <= 1'b0;
         load_q <= 1'b0;
      end else if (CE) begin
         fs_q   <= fs_d;
         cnt_q  <= cnt_d;
         full_q <= full_d;
         load_q <= load_d;
      end
   end

   assign FANS_FULL     = full_q;
   assign LOAD_DEFAULTS = load_q;
   assign NORMAL_OP     = (fs_q == SFS_NORMAL);

   ////////////////////////////////////////////////////////////////////////////
   prot_entry_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && adapt_one[SFS_STBY_OPT_BIT] && ON_STANDBY && CORE_RAIL_BELOW_LOW |=> prot_q)
      else $error("Protection not entered on low core rail.");
   core_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $rose(prot_q) |-> flag_q)
      else $error("Core rail flag missing on entry.");
   alert_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $rose(prot_q) && CORE_ALERT_EN |-> SMBALERT_OE && !SMBALERT_N_O)
      else $error("Alert not driven on entry.");
   thermal_event_pin_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      prot_q |=> $stable(ttmr_q))
      else $error("Thermal timer moved during protection.");
   fan_start_temperature_freeze_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      prot_q |-> !DYN_FAN_START_TEMPERATURE_ALLOW)
      else $error("Fan-start adjustment allowed during protection.");
   no_shutdown_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      prot_q && SHUTDOWN_REQ |-> !SHUTDOWN_ENTER)
      else $error("Shutdown entered during protection.");
   resume_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && !CORE_RAIL_BELOW_LOW |=> !prot_q && DYN_FAN_START_TEMPERATURE_ALLOW)
      else $error("Protection held after rail recovery.");
   board_test_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && REG_WR && !load_q && REG_ADDR == SFS_ADDR_BOARD_TEST && REG_WDATA[0]
      |=> BOARD_TEST_EN)
      else $error("Board test not enabled by write.");
   poll_default_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && fs_q == SFS_POLL && addressed |=> LOAD_DEFAULTS && NORMAL_OP && !FANS_FULL)
      else $error("Defaults not loaded from poll.");
   timeout_full_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && fs_q == SFS_COUNT && cnt_q == FS_LAST && !addressed |=> FANS_FULL)
      else $error("Fans not forced full at timeout.");
   failsafe_stop_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && fs_q == SFS_FULL && addressed
      |=> (!FANS_FULL && LOAD_DEFAULTS) and (CE |=> !LOAD_DEFAULTS))
      else $error("Fail-safe not released by addressing.");
   early_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && fs_q == SFS_COUNT && addressed |=> NORMAL_OP && !FANS_FULL && LOAD_DEFAULTS)
      else $error("Early addressing did not start normal operation.");
   foreign_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && fs_q == SFS_COUNT && !ADDR_ACK |=> !NORMAL_OP)
      else $error("Unacknowledged traffic stopped the countdown.");
   count_step_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && fs_q == SFS_COUNT && !addressed && cnt_q != FS_LAST
      |=> cnt_q == $past(cnt_q) + SFS_FS_CNT_W'(1))
      else $error("Fail-safe counter did not advance.");
endmodule

//--- test/sfs_host_model.sv
// Behavioural model of the board's bus host as seen by the supervisor's addressing inputs.
// Assumes the bench pulses go for one cycle and holds ack_en and lag until the match is sent.
`timescale 1ns/100ps
module sfs_host_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       ack_en,
   input  wire logic [3:0] lag,
   output logic            match,
   output logic            ack
);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      match = 1'b0;
      ack   = 1'b0;
   end

   // A lagging host holds the match back lag cycles after go; the bench checks the fans only after it lands.
   always @(posedge clk) begin
      if (go) begin
         repeat (lag) @(posedge clk);
         #1 match <= 1'b1;
         ack      <= ack_en;
         @(posedge clk);
         #1 match <= 1'b0;
         ack      <= 1'b0;
      end
   end
endmodule

//--- test/testbench.sv
// Self-checking bench for the supervisor: registers, fail-safe timer and standby protection.
// Assumes the fail-safe count is shortened by parameter and inputs move 1 ns after the edge.
`timescale 1ns/100ps
module testbench;
   import sfs_pkg::*;
   localparam int unsigned N = 20;
   logic clk, rst_n, ce, wr, rd, stby, below, above, alert_en, flag_clr, thermal_event_pin_n, shut_req;
   logic [7:0] addr, wdata, rdata;
   logic match, ack, go, ack_en, alert_n_o, alert_oe, flag, prot, dyn, shut, bt_en;
   logic fans_full, load_dflt, normal_op, alert_wire;
   logic [3:0] lag;
   logic [15:0] thermal_event_pin_tmr, held;
   int err_total, total_checks, cyc, rel_cyc;
   ////////////////////////////////////////////////////////////////////////////////
   sfs_supervisor #(.FAILSAFE_CYCLES(N)) sfs_supervisor_inst (
      .CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .ADDR_MATCH(match), .ADDR_ACK(ack),
      .ON_STANDBY(stby), .CORE_RAIL_BELOW_LOW(below), .CORE_RAIL_ABOVE_POLL(above),
      .CORE_ALERT_EN(alert_en), .CORE_FLAG_CLR(flag_clr), .THERMAL_EVENT_PIN_EVENT_N(thermal_event_pin_n),
      .SHUTDOWN_REQ(shut_req), .SMBALERT_N_I(alert_wire), .SMBALERT_N_O(alert_n_o),
      .SMBALERT_OE(alert_oe), .CORE_RAIL_FLAG(flag), .STBY_PROTECT(prot),
      .THERMAL_EVENT_PIN_TIMER(thermal_event_pin_tmr), .DYN_FAN_START_TEMPERATURE_ALLOW(dyn), .SHUTDOWN_ENTER(shut),
      .BOARD_TEST_EN(bt_en), .FANS_FULL(fans_full), .LOAD_DEFAULTS(load_dflt),
      .NORMAL_OP(normal_op));
   sfs_host_model sfs_host_model_inst (.clk(clk), .go(go), .ack_en(ack_en), .lag(lag),
      .match(match), .ack(ack));
   // The alert line is open drain with a board pull-up.
   assign alert_wire = alert_oe ? alert_n_o : 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1 wr = 1'b1;
      addr  = a;
      wdata = d;
      @(posedge clk) #1 wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) #1 rd = 1'b1;
      addr = a;
      @(posedge clk) #1 rd = 1'b0;
      chk("read data", {8'h00, exp}, {8'h00, rdata});
   endtask
   task automatic addr_dev(input logic a, input logic [3:0] l);
      @(posedge clk) #1 go = 1'b1;
      ack_en = a;
      lag    = l;
      @(posedge clk) #1 go = 1'b0;
      repeat (l + 1) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic rail_up);
      rst_n = 1'b0;
      above = rail_up;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      rel_cyc = cyc;
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // A hung wait is cut off well beyond the roughly 150 cycles the tests need.
   always @(posedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      {wr, rd, stby, below, alert_en, flag_clr, shut_req, go, ack_en} = '0;
      {ce, thermal_event_pin_n} = 2'b11;
      addr  = 8'h00;
      wdata = 8'h00;
      lag   = 4'h0;
      do_reset(1'b1);
      rd_reg(SFS_ADDR_ADAPT_ONE, 8'h00);
      rd_reg(SFS_ADDR_BOARD_TEST, 8'h00);
      addr_dev(1'b0, 4'h0);
      chk("normal", 16'h0000, {15'h0, normal_op});
      wr_reg(SFS_ADDR_BOARD_TEST, 8'h01);
      chk("board test", 16'h0001, {15'h0, bt_en});
      chk("fans early", 16'h0000, {15'h0, fans_full});
      for (int i = 0; i < 40 && fans_full !== 1'b1; i++) @(posedge clk) #1;
      chk("fans late", 16'h0001, {15'h0, fans_full});
      chk("fail-safe delay", 16'(N + 1), 16'(cyc - rel_cyc));
      addr_dev(1'b1, 4'h3);
      chk("fans stop", 16'h0000, {15'h0, fans_full});
      chk("defaults", 16'h0001, {15'h0, load_dflt});
      chk("normal", 16'h0001, {15'h0, normal_op});
      @(posedge clk) #1;
      chk("test cleared", 16'h0000, {15'h0, bt_en});
      wr_reg(8'h40, 8'hFF);
      wr_reg(SFS_ADDR_ADAPT_ONE, 8'h02);
      rd_reg(SFS_ADDR_ADAPT_ONE, 8'h02);
      // The unmapped read follows a nonzero read, so stale data would show.
      rd_reg(8'h40, SFS_UNMAPPED_READ);
      rd_reg(SFS_ADDR_BOARD_TEST, 8'h00);
      {stby, alert_en, shut_req, thermal_event_pin_n} = 4'b1110;
      below    = 1'b1;
      flag_clr = 1'b1;
      @(posedge clk) #1 held = thermal_event_pin_tmr;
      flag_clr = 1'b0;
      chk("protect", 16'h0001, {15'h0, prot});
      chk("flag", 16'h0001, {15'h0, flag});
      chk("alert wire", 16'h0000, {15'h0, alert_wire});
      chk("shutdown", 16'h0000, {15'h0, shut});
      chk("fan start adjust", 16'h0000, {15'h0, dyn});
      repeat (5) @(posedge clk);
      #1 chk("thermal_event_pin timer", held, thermal_event_pin_tmr);
      below = 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("protect off", 16'h0000, {15'h0, prot});
      chk("shutdown on", 16'h0001, {15'h0, shut});
      chk("adjust on", 16'h0001, {15'h0, dyn});
      chk("thermal_event_pin runs", 16'h0001, {15'h0, thermal_event_pin_tmr > held});
      chk("flag sticky", 16'h0001, {15'h0, flag});
      flag_clr = 1'b1;
      @(posedge clk) #1 flag_clr = 1'b0;
      chk("flag cleared", 16'h0000, {15'h0, flag});
      chk("alert released", 16'h0001, {15'h0, alert_wire});
      do_reset(1'b0);
      repeat (N + 10) @(posedge clk);
      #1 chk("no fail-safe", 16'h0000, {15'h0, fans_full});
      addr_dev(1'b1, 4'h0);
      chk("defaults low rail", 16'h0001, {15'h0, load_dflt});
      chk("normal low rail", 16'h0001, {15'h0, normal_op});
      // With the clock enable low, addressing must leave the state alone.
      do_reset(1'b1);
      ce = 1'b0;
      addr_dev(1'b1, 4'h0);
      chk("frozen", 16'h0000, {15'h0, normal_op});
      ce = 1'b1;
      addr_dev(1'b1, 4'h0);
      chk("defaults early", 16'h0001, {15'h0, load_dflt});
      chk("normal early", 16'h0001, {15'h0, normal_op});
      repeat (N + 10) @(posedge clk);
      #1 chk("no late fail-safe", 16'h0000, {15'h0, fans_full});
      report_and_stop();
   end
endmodule
